// ---- rtl/tope_defs.vh ----
`ifndef TOPE_DEFS_VH
`define TOPE_DEFS_VH
// ==================================================
// Register byte offsets (APB, one word each)
`define TOPE_OFS_CTRL 8'h00
`define TOPE_OFS_SLAVE 8'h04
`define TOPE_OFS_CHAN 8'h08
`define TOPE_OFS_COUNT 8'h0C
`define TOPE_OFS_CMP1 8'h10
`define TOPE_OFS_RELOAD 8'h14
`define TOPE_OFS_EVENT 8'h18
`define TOPE_OFS_STATUS 8'h1C
// ==================================================
// Control register fields
`define TOPE_CTRL_RUN 0
`define TOPE_CTRL_SPM 3
`define TOPE_CTRL_DIR 4
`define TOPE_CTRL_CMS_LO 5
`define TOPE_CTRL_CMS_HI 6
`define TOPE_CTRL_RLPE 7
// Slave register fields
`define TOPE_SMS_LO 0
`define TOPE_SMS_HI 2
`define TOPE_TS_LO 4
`define TOPE_TS_HI 6
// Channel and event register fields
`define TOPE_CH1_SEL_LO 0
`define TOPE_CH1_SEL_HI 1
`define TOPE_CH1_FE 2
`define TOPE_CH1_PE 3
`define TOPE_CH1_OM_LO 4
`define TOPE_CH1_OM_HI 6
`define TOPE_CH2_SEL_LO 8
`define TOPE_CH2_SEL_HI 9
`define TOPE_CH1_POL 12
`define TOPE_CH2_POL 13
`define TOPE_EVT_UG 0
// ==================================================
// Codes
`define TOPE_SMS_OFF 3'h0
`define TOPE_SMS_ENC2 3'h1
`define TOPE_SMS_ENC1 3'h2
`define TOPE_SMS_ENC12 3'h3
`define TOPE_SMS_TRIG 3'h6
`define TOPE_TS_CH2F 3'h6
`define TOPE_SEL_PIN 2'h1
`define TOPE_OM_PWM1 3'h6
`define TOPE_OM_PWM2 3'h7
// ==================================================
// Reset values and sync depth
`define TOPE_CTRL_RST 8'h00
`define TOPE_SLAVE_RST 8'h00
`define TOPE_CHAN_RST 16'h0000
`define TOPE_RELOAD_RST 16'hFFFF
`define TOPE_SYNC_STAGES 2
`endif

// ---- rtl/tope_sync.v ----
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Two-stage synchroniser for one pin input
module tope_sync (
    input wire pclk,
    input wire presetn,
    input wire pin_in,
    output wire pin_sync
);
    reg meta_r; // First stage, read only by second stage
    reg sync_r; // Second stage, safe to use
    // Shift the pin through two flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end
    assign pin_sync = sync_r;
endmodule
`default_nettype wire

// ---- rtl/tope_timer.v ----
`timescale 1ns/100ps
`default_nettype none
`include "tope_defs.vh"
// ==================================================
// One-pulse and encoder timer, APB slave
module tope_timer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire chan1_pin_input,
    input wire chan2_pin_input,
    output reg channel_output_pin,
    output reg counter_run_out
);
    // ==================================================
    // Configuration registers
    reg [7:0] ctrl_r; // Run, single pulse, dir, center, reload preload
    reg [7:0] slave_r; // Slave mode and trigger source
    reg [15:0] chan_r; // Channel selects, fast, preload, mode, polarity
    reg [15:0] count_r; // Counter
    reg [15:0] cmp_buf_r; // Compare value as written
    reg [15:0] cmp_act_r; // Compare value in use
    reg [15:0] rld_buf_r; // Reload value as written
    reg [15:0] rld_act_r; // Reload value in use
    reg ref_r; // Reference output
    reg prev1_r; // Last polarity-adjusted chan1
    reg prev2_r; // Last polarity-adjusted chan2
    reg upd_seen_r; // Sticky update flag for status
    reg fast_r; // Fast-path level held until the compare catches up

    wire run_bit = ctrl_r[`TOPE_CTRL_RUN];
    wire spm_bit = ctrl_r[`TOPE_CTRL_SPM];
    wire dir_bit = ctrl_r[`TOPE_CTRL_DIR];
    wire [2:0] slave_mode_select = slave_r[`TOPE_SMS_HI:`TOPE_SMS_LO];
    wire [2:0] tss = slave_r[`TOPE_TS_HI:`TOPE_TS_LO];
    wire [2:0] om1 = chan_r[`TOPE_CH1_OM_HI:`TOPE_CH1_OM_LO];
    wire fe1 = chan_r[`TOPE_CH1_FE];
    wire [1:0] sel2 = chan_r[`TOPE_CH2_SEL_HI:`TOPE_CH2_SEL_LO];

    // ==================================================
    // Pin resynchronisation
    wire ch1_s;
    wire ch2_s;
    tope_sync u_sync1 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(chan1_pin_input),
        .pin_sync(ch1_s)
    );
    tope_sync u_sync2 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(chan2_pin_input),
        .pin_sync(ch2_s)
    );

    // Polarity selection ahead of edge evaluation
    wire chan1_filtered_input = ch1_s ^ chan_r[`TOPE_CH1_POL];
    wire chan2_filtered_input = ch2_s ^ chan_r[`TOPE_CH2_POL];
    wire t1_edge = chan1_filtered_input ^ prev1_r;
    wire t2_edge = chan2_filtered_input ^ prev2_r;

    // ==================================================
    // Trigger path: chan2 filtered input as rising-edge trigger
    wire ch2_routed = (sel2 == `TOPE_SEL_PIN);
    wire trigger_input = (tss == `TOPE_TS_CH2F) && ch2_routed
        && t2_edge && chan2_filtered_input;
    wire trig_start = (slave_mode_select == `TOPE_SMS_TRIG) && trigger_input;

    // ==================================================
    // Encoder decode, direction from the opposite level
    wire enc_mode = (slave_mode_select == `TOPE_SMS_ENC1) || (slave_mode_select == `TOPE_SMS_ENC2)
        || (slave_mode_select == `TOPE_SMS_ENC12);
    wire use1 = (slave_mode_select == `TOPE_SMS_ENC1) || (slave_mode_select == `TOPE_SMS_ENC12);
    wire use2 = (slave_mode_select == `TOPE_SMS_ENC2) || (slave_mode_select == `TOPE_SMS_ENC12);
    // Chan1 edge: down when new level equals opposite level
    wire dn1 = ~(chan1_filtered_input ^ chan2_filtered_input);
    // Chan2 edge: down when new level differs from opposite level
    wire dn2 = chan1_filtered_input ^ chan2_filtered_input;
    reg enc_step;
    reg enc_dir;
    // Work out step and direction for this cycle
    always @* begin
        enc_step = 1'b0;
        enc_dir = dir_bit;
        if (enc_mode) begin
            // Direction follows any input transition
            if (t1_edge) begin
                enc_dir = dn1;
            end else if (t2_edge) begin
                enc_dir = dn2;
            end
            // Only selected channels produce count pulses
            enc_step = (t1_edge && use1) || (t2_edge && use2);
        end
    end

    // ==================================================
    // Counter next value and update event
    wire counting = run_bit && (!enc_mode || enc_step);
    wire cnt_dir = enc_mode ? enc_dir : dir_bit;
    wire at_top = (count_r == rld_act_r);
    wire at_bot = (count_r == 16'h0000);
    reg [15:0] count_nxt;
    reg ovf;
    // Step the counter, wrapping between 0 and reload
    always @* begin
        count_nxt = count_r;
        ovf = 1'b0;
        if (counting) begin
            if (!cnt_dir) begin
                if (at_top) begin
                    count_nxt = 16'h0000;
                    ovf = 1'b1;
                end else begin
                    count_nxt = count_r + 16'h0001;
                end
            end else begin
                if (at_bot) begin
                    count_nxt = rld_act_r;
                    ovf = 1'b1;
                end else begin
                    count_nxt = count_r - 16'h0001;
                end
            end
        end
    end

    // ==================================================
    // APB decode, zero wait states
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire ug = wr && (paddr == `TOPE_OFS_EVENT) && pwdata[`TOPE_EVT_UG];
    wire wr_cnt = wr && (paddr == `TOPE_OFS_COUNT);
    wire upd = ovf || ug; // Update event
    wire pwm_mode = (om1 == `TOPE_OM_PWM1) || (om1 == `TOPE_OM_PWM2);
    wire known = (paddr == `TOPE_OFS_CTRL) || (paddr == `TOPE_OFS_SLAVE)
        || (paddr == `TOPE_OFS_CHAN) || (paddr == `TOPE_OFS_COUNT)
        || (paddr == `TOPE_OFS_CMP1) || (paddr == `TOPE_OFS_RELOAD)
        || (paddr == `TOPE_OFS_EVENT) || (paddr == `TOPE_OFS_STATUS);

    // Control register: software writes, trigger sets run, update clears it in single-pulse mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `TOPE_CTRL_RST;
        end else begin
            if (wr && paddr == `TOPE_OFS_CTRL) begin
                ctrl_r <= pwdata[7:0];
            end else begin
                if (enc_mode && enc_step) begin
                    ctrl_r[`TOPE_CTRL_DIR] <= enc_dir;
                end else if (enc_mode && t1_edge | t2_edge) begin
                    ctrl_r[`TOPE_CTRL_DIR] <= enc_dir;
                end
                // Hardware start wins if it meets a stop in the same cycle
                if (trig_start) begin
                    ctrl_r[`TOPE_CTRL_RUN] <= 1'b1;
                end else if (spm_bit && upd && run_bit) begin
                    ctrl_r[`TOPE_CTRL_RUN] <= 1'b0;
                end
            end
        end
    end

    // Slave and channel configuration
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_r <= `TOPE_SLAVE_RST;
            chan_r <= `TOPE_CHAN_RST;
        end else begin
            if (wr && paddr == `TOPE_OFS_SLAVE) begin
                slave_r <= pwdata[7:0];
            end
            if (wr && paddr == `TOPE_OFS_CHAN) begin
                chan_r <= pwdata[15:0];
            end
        end
    end

    // Compare and reload with optional preload, copied on update
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_buf_r <= 16'h0000;
            cmp_act_r <= 16'h0000;
            rld_buf_r <= `TOPE_RELOAD_RST;
            rld_act_r <= `TOPE_RELOAD_RST;
        end else begin
            if (wr && paddr == `TOPE_OFS_CMP1) begin
                cmp_buf_r <= pwdata[15:0];
                if (!chan_r[`TOPE_CH1_PE]) begin
                    cmp_act_r <= pwdata[15:0];
                end
            end else if (upd) begin
                cmp_act_r <= cmp_buf_r;
            end
            if (wr && paddr == `TOPE_OFS_RELOAD) begin
                rld_buf_r <= pwdata[15:0];
                if (!ctrl_r[`TOPE_CTRL_RLPE]) begin
                    rld_act_r <= pwdata[15:0];
                end
            end else if (upd) begin
                rld_act_r <= rld_buf_r;
            end
        end
    end

    // Counter: software write, forced update, or counting step
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 16'h0000;
        end else if (wr_cnt) begin
            count_r <= pwdata[15:0];
        end else if (ug) begin
            // Forced update restarts from the bottom for up-counting
            count_r <= dir_bit ? rld_act_r : 16'h0000;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Edge history of the polarity-adjusted inputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev1_r <= 1'b0;
            prev2_r <= 1'b0;
        end else begin
            prev1_r <= chan1_filtered_input;
            prev2_r <= chan2_filtered_input;
        end
    end

    // ==================================================
    // Reference output: PWM compare, fast path on trigger
    // Mode 1 active while below compare, mode 2 the opposite except at reload, so
    // mode 2 rises at match and falls as the counter reaches reload.
    wire below = (count_r < cmp_act_r);
    // Mode 2 drops as the counter reaches reload, so the pulse lasts
    // reload minus compare ticks
    wire pwm2_lvl = !below && !at_top;
    reg ref_nxt;
    // Choose the reference level
    always @* begin
        case (om1)
            `TOPE_OM_PWM1: ref_nxt = below;
            `TOPE_OM_PWM2: ref_nxt = pwm2_lvl;
            default: ref_nxt = ref_r;
        endcase
        if (!run_bit && spm_bit && !trig_start) begin
            // Stopped single pulse keeps the PWM level of the held counter
            ref_nxt = (om1 == `TOPE_OM_PWM1) ? below : pwm2_lvl;
            if (!pwm_mode) begin
                ref_nxt = ref_r;
            end
        end
        if (fast_r && below && run_bit && pwm_mode) begin
            // Keep the forced level until the real match agrees with it
            ref_nxt = (om1 == `TOPE_OM_PWM2);
        end
        if (trig_start && fe1 && pwm_mode) begin
            // Skip the compare latency: match level right away
            ref_nxt = (om1 == `TOPE_OM_PWM2);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_r <= 1'b0;
        end else begin
            ref_r <= ref_nxt;
        end
    end

    // Fast-path hold: set by the trigger, dropped once compare is reached
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_r <= 1'b0;
        end else if (trig_start && fe1 && pwm_mode) begin
            fast_r <= 1'b1;
        end else if (!below || !run_bit) begin
            fast_r <= 1'b0;
        end
    end

    // ==================================================
    // Registered outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_output_pin <= 1'b0;
            counter_run_out <= 1'b0;
            upd_seen_r <= 1'b0;
        end else begin
            channel_output_pin <= ref_nxt;
            counter_run_out <= run_bit;
            // Set wins over a status clear write in the same cycle
            if (upd) begin
                upd_seen_r <= 1'b1;
            end else if (wr && paddr == `TOPE_OFS_STATUS && pwdata[0]) begin
                upd_seen_r <= 1'b0;
            end
        end
    end

    // ==================================================
    // APB answer: ready in the access cycle, error on unmapped
    reg [31:0] rd_mux;
    always @* begin
        case (paddr)
            `TOPE_OFS_CTRL: rd_mux = {24'h000000, ctrl_r};
            `TOPE_OFS_SLAVE: rd_mux = {24'h000000, slave_r};
            `TOPE_OFS_CHAN: rd_mux = {16'h0000, chan_r};
            `TOPE_OFS_COUNT: rd_mux = {16'h0000, count_r};
            `TOPE_OFS_CMP1: rd_mux = {16'h0000, cmp_buf_r};
            `TOPE_OFS_RELOAD: rd_mux = {16'h0000, rld_buf_r};
            `TOPE_OFS_STATUS: rd_mux = {29'h0000000, ref_r, run_bit, upd_seen_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Ready is registered: it goes high in the setup cycle's successor
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tope_timer_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tope_defs.vh"
// ====
// Port checker: APB timing, trigger latency, pulse shape
module tope_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan1_pin_input,
    input wire logic chan2_pin_input,
    input wire logic channel_output_pin,
    input wire logic counter_run_out
);
    logic [7:0] slv_r; // Copy of slave register
    logic [15:0] chn_r; // Copy of channel register
    logic trig_cfg; // Rising-edge trigger on channel 2 set up
    // Track completed writes only, as the slave sees them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slv_r <= 8'h00;
            chn_r <= 16'h0000;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == `TOPE_OFS_SLAVE)
                slv_r <= pwdata[7:0];
            if (paddr == `TOPE_OFS_CHAN)
                chn_r <= pwdata[15:0];
        end
    end
    assign trig_cfg = slv_r == 8'h66 && chn_r[9:8] == 2'h1 && !chn_r[13];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rise2;
        trig_cfg && $rose(chan2_pin_input) && !counter_run_out;
    endsequence
    property p_answer;
        s_setup |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_unmap;
        pready && paddr > 8'h1C |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_idle;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_idle: assert property (p_idle) else $error("bus outputs not quiet");
    property p_rst;
        $rose(presetn) |-> !counter_run_out && !channel_output_pin;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    // Two sync flops hold the edge back before the run bit moves
    property p_trig;
        s_rise2 |-> !counter_run_out [*4] ##1 counter_run_out;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger start late or early");
    property p_fall;
        trig_cfg && $fell(chan2_pin_input) && !counter_run_out |-> !counter_run_out [*6];
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge started counter");
    property p_up;
        $rose(channel_output_pin) |-> ##[0:1] counter_run_out;
    endproperty
    a_up: assert property (p_up) else $error("output rose with counter idle");
    property p_stop;
        $fell(channel_output_pin) |-> ##[0:2] !counter_run_out;
    endproperty
    a_stop: assert property (p_stop) else $error("counter ran on after pulse");
endmodule
bind tope_timer tope_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan1_pin_input(chan1_pin_input), .chan2_pin_input(chan2_pin_input),
    .channel_output_pin(channel_output_pin), .counter_run_out(counter_run_out));
`default_nettype wire

// ---- tb/tope_enc.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// Quadrature encoder and trigger source
module tope_enc (
    input wire logic pclk,
    output logic enc_a,
    output logic enc_b
);
    logic [1:0] pos_r; // Phase 0..3 = ab 00,10,11,01
    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        pos_r = 2'h0;
    end
    // One phase step, then a gap; only one line moves per step
    task automatic step(input logic up, input int gap);
        pos_r = up ? pos_r + 2'h1 : pos_r - 2'h1;
        @(posedge pclk);
        enc_a <= pos_r == 2'h1 || pos_r == 2'h2;
        enc_b <= pos_r[1];
        repeat (gap) @(posedge pclk);
    endtask
    // Trigger line level, used with the encoder at rest
    task automatic level(input logic v);
        @(posedge pclk);
        enc_b <= v;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tope_defs.vh"
// ====
// Register-level tests of encoder and single-pulse modes
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ch1, ch2, out_pin, run_out;
    int err_count, check_count, i, j, rise, wid;
    logic [2:0] sms_t[5] = '{3'h3, 3'h3, 3'h1, 3'h2, 3'h3}; // Slave codes
    logic up_t[5] = '{1, 0, 1, 0, 1}; // Step direction
    logic pol_t[5] = '{0, 0, 0, 0, 1}; // Channel 1 inversion
    int n_t[5] = '{4, 3, 4, 4, 4}; // Steps
    logic [31:0] cnt_t[5] = '{0, 5, 4, 0, 4}; // Count from 2, reload 5
    tope_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan1_pin_input(ch1),
        .chan2_pin_input(ch2), .channel_output_pin(out_pin), .counter_run_out(run_out));
    tope_enc i_enc (.pclk(pclk), .enc_a(ch1), .enc_b(ch2));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits an edge first so signals never change twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No cycle count assumed; the watchdog ends a hung wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    // Trigger once; give output delay from run start and pulse width
    task automatic pulse(output int r, output int w);
        int t, t_run, t_up, t_dn;
        t_run = -1;
        t_up = -1;
        t_dn = -1;
        i_enc.level(1'b1);
        for (t = 0; t < 40; t++) begin
            @(posedge pclk);
            if (run_out === 1'b1 && t_run < 0)
                t_run = t;
            if (out_pin === 1'b1 && t_up < 0)
                t_up = t;
            if (out_pin === 1'b0 && t_up >= 0 && t_dn < 0)
                t_dn = t;
        end
        r = t_up < 0 ? -99 : t_up - t_run;
        w = t_dn - t_up;
        i_enc.level(1'b0);
        repeat (8) @(posedge pclk);
    endtask
    task automatic end_sim;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #500000;
        err_count++;
        end_sim;
    end
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_count = 0;
        check_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TOPE_OFS_CTRL, 32'h0, 1'b0);
        rd(`TOPE_OFS_SLAVE, 32'h0, 1'b0);
        rd(`TOPE_OFS_CHAN, 32'h0, 1'b0);
        rd(`TOPE_OFS_RELOAD, 32'h0000FFFF, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        wr(`TOPE_OFS_RELOAD, 32'h5);
        wr(`TOPE_OFS_CTRL, 32'h1);
        for (i = 0; i < 5; i++) begin
            wr(`TOPE_OFS_SLAVE, {29'h0, sms_t[i]});
            wr(`TOPE_OFS_CHAN, 32'h101 | {pol_t[i], 12'h0});
            repeat (6) @(posedge pclk);
            wr(`TOPE_OFS_COUNT, 32'h2);
            for (j = 0; j < n_t[i]; j++)
                i_enc.step(up_t[i], 3 + 5 * i);
            repeat (5) @(posedge pclk);
            rd(`TOPE_OFS_COUNT, cnt_t[i], 1'b0);
            rd(`TOPE_OFS_CTRL, {27'h0, !up_t[i] ^ pol_t[i], 4'h1}, 1'b0);
        end
        // Single pulse: reload 8, compare 3, PWM mode 2 with preloads
        wr(`TOPE_OFS_CTRL, 32'h0);
        wr(`TOPE_OFS_SLAVE, 32'h0);
        // Park the counter below compare so mode 2 stays low while idle
        wr(`TOPE_OFS_COUNT, 32'h0);
        i_enc.level(1'b0);
        wr(`TOPE_OFS_RELOAD, 32'h8);
        wr(`TOPE_OFS_CMP1, 32'h3);
        wr(`TOPE_OFS_CHAN, 32'h178);
        wr(`TOPE_OFS_CTRL, 32'h88);
        wr(`TOPE_OFS_EVENT, 32'h1);
        rd(`TOPE_OFS_COUNT, 32'h0, 1'b0);
        wr(`TOPE_OFS_SLAVE, 32'h66);
        pulse(rise, wid);
        chk(rise, 3);
        chk(wid, 5);
        rd(`TOPE_OFS_CTRL, 32'h88, 1'b0);
        rd(`TOPE_OFS_COUNT, 32'h0, 1'b0);
        rd(`TOPE_OFS_STATUS, 32'h1, 1'b0);
        // Fast path with a long delay, then fast bit in a frozen mode
        wr(`TOPE_OFS_CMP1, 32'h6);
        wr(`TOPE_OFS_EVENT, 32'h1);
        wr(`TOPE_OFS_CHAN, 32'h17C);
        pulse(rise, wid);
        chk({31'h0, rise < 2}, 32'h1);
        chk(wid, 9);
        wr(`TOPE_OFS_CHAN, 32'h104);
        pulse(rise, wid);
        chk(rise, -99);
        rd(`TOPE_OFS_CTRL, 32'h88, 1'b0);
        end_sim;
    end
endmodule
`default_nettype wire
